// [host_port_map.svh]
// host_port_map.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and both ends
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// register-select codes in multiplexed mode
`define HP_SEL_CONTROL 2'h0
`define HP_SEL_ADDR_INC 2'h1
`define HP_SEL_ADDR 2'h2
`define HP_SEL_DATA 2'h3
// control register field positions
`define HP_CTRL_IRQ_A_BIT 0
`define HP_CTRL_IRQ_B_BIT 1
`define HP_CTRL_RESET 16'h0000
// widths
`define HP_DATA_W 16
`define HP_ADDR_W 18
// device busy cycles per data transfer
`define HP_BUSY_CYCLES 4'h3

`endif

// [host_port_pkg.sv]
// host_port_pkg.sv: types shared by both ends of the host port
// assumes host_port_map.svh is on the include path
`include "host_port_map.svh"

package host_port_pkg;
    typedef logic [`HP_DATA_W-1:0] word_t;
    typedef logic [`HP_ADDR_W-1:0] addr_t;
    typedef enum logic [1:0] {REQ_READ, REQ_WRITE, REQ_ADDR, REQ_CTRL} req_kind_t;
endpackage : host_port_pkg

// [host_port_if.sv]
// host_port_if.sv: pin bundle between host and device ends
// assumes a single clock; the bench resolves the data bus from enables
`timescale 1ns/1ps
`default_nettype none

interface host_port_if;
    logic iface_select_pin;
    logic host_mode_pin;
    logic host_port_reset_pin_n;
    logic host_chip_select_n;
    logic host_strobe_one_n;
    logic host_strobe_two_n;
    logic host_dir_select;
    logic host_addr_strobe_n;
    logic host_reg_select_0;
    logic host_reg_select_1;
    logic [17:0] host_addr_bus;
    logic [15:0] hd_to_dev;
    logic [15:0] hd_from_dev;
    logic hd_dev_oe;
    logic [15:0] hd_from_host;
    logic hd_host_oe;
    logic off_n;
    logic host_ready_out;
    logic host_ready_oe;
    logic host_irq_out_a_n;
    logic host_irq_out_b_n;
    logic host_irq_oe;

    modport device (
        input iface_select_pin, host_mode_pin, host_port_reset_pin_n, host_chip_select_n,
        input host_strobe_one_n, host_strobe_two_n, host_dir_select, host_addr_strobe_n,
        input host_reg_select_0, host_reg_select_1, host_addr_bus, hd_to_dev, off_n,
        output hd_from_dev, hd_dev_oe, host_ready_out, host_ready_oe,
        output host_irq_out_a_n, host_irq_out_b_n, host_irq_oe
    );
    modport host (
        output iface_select_pin, host_mode_pin, host_port_reset_pin_n, host_chip_select_n,
        output host_strobe_one_n, host_strobe_two_n, host_dir_select, host_addr_strobe_n,
        output host_reg_select_0, host_reg_select_1, host_addr_bus, hd_from_host, hd_host_oe,
        input hd_to_dev, host_ready_out, host_irq_out_a_n, host_irq_out_b_n
    );
endinterface : host_port_if

`default_nettype wire

// [host_port_device.sv]
// host_port_device.sv: device end of the parallel host port
// assumes pins synchronous to clk; RAM side is a valid/ready write port and a req/valid read port
// Function
// [R01] pins act as host port only when select low
// [R02] chip select may stay low across transfers
// [R03] host strobes frame each transfer
// [R04] direction line picks read or write
// [R05] ready output paces host transfers
// [R06] ready and interrupts float when off low
// [R07] per-subsystem interrupt outputs, active low
// [R08] writing one to bit clears interrupt
// [R09] interrupts only in multiplexed mode
// [R10] reset pin resets port and subsystems
// [R11] mode low: multiplexed register access
// [R12] mode high: 18-bit address, 16-bit data
// [R13] no interrupts in non-multiplexed mode
// [R14] chip select held through each transfer
// [R15] address strobe latches address register
// [R16] select inputs pick control, address, data
// [R17] host waits for ready before strobing
// [R18] reset holds ready low, interrupts released
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module host_port_device #(
    parameter logic [3:0] BUSY_CYCLES = `HP_BUSY_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    host_port_if.device pins,
    // ram-side write stream (host writes) through two-entry buffer
    output logic ram_wr_valid,
    input wire logic ram_wr_ready,
    output host_port_pkg::addr_t ram_wr_addr,
    output host_port_pkg::word_t ram_wr_data,
    // ram-side read: word returned for the current address
    output logic ram_rd_req,
    output host_port_pkg::addr_t ram_rd_addr,
    input wire logic ram_rd_valid,
    input wire host_port_pkg::word_t ram_rd_data,
    // per-subsystem requests to interrupt the host, one-cycle pulses
    input wire logic dsp_irq_set_a,
    input wire logic dsp_irq_set_b,
    output logic subsys_reset
);
    // ************************************************************
    // strobe decode
    // ************************************************************
    logic port_rst;
    logic active;
    logic strobe_n;
    logic strobe_d_reg;
    logic strobe_fall;
    logic strobe_rise;
    logic as_d_reg;
    logic as_fall;
    logic muxed;
    logic [1:0] sel;

    assign port_rst = rst | ~pins.host_port_reset_pin_n; // R10
    assign active = ~pins.iface_select_pin & ~pins.host_chip_select_n; // R01 R14
    assign strobe_n = pins.host_strobe_one_n & pins.host_strobe_two_n;
    assign strobe_fall = active & ~strobe_n & strobe_d_reg; // R03 R02
    assign strobe_rise = ~strobe_d_reg & strobe_n;
    assign muxed = ~pins.host_mode_pin; // R11
    assign sel = {pins.host_reg_select_1, pins.host_reg_select_0}; // R16
    assign as_fall = active & muxed & ~pins.host_addr_strobe_n & as_d_reg;

    // strobe edge history
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            strobe_d_reg <= 1'b1;
            as_d_reg <= 1'b1;
        end
        else
        begin
            strobe_d_reg <= strobe_n;
            as_d_reg <= pins.host_addr_strobe_n;
        end
    end

    // ************************************************************
    // address register
    // ************************************************************
    host_port_pkg::addr_t addr_reg;
    logic data_access;
    logic addr_inc;
    assign data_access = strobe_fall & (~muxed | sel == `HP_SEL_DATA | sel == `HP_SEL_ADDR_INC);
    assign addr_inc = strobe_rise & muxed & (sel == `HP_SEL_ADDR_INC);

    // latch on address strobe, register write, non-multiplexed strobe from the address bus, or post-increment
    always_ff @(posedge clk)
    begin
        if (port_rst)
            addr_reg <= '0;
        else if (as_fall)
            addr_reg <= {2'b00, pins.hd_to_dev}; // R15
        else if (strobe_fall & muxed & sel == `HP_SEL_ADDR & ~pins.host_dir_select)
            addr_reg <= {2'b00, pins.hd_to_dev}; // R16
        else if (strobe_fall & ~muxed)
            addr_reg <= pins.host_addr_bus; // R12
        else if (addr_inc)
            addr_reg <= addr_reg + 18'h0_0001;
    end

    // ************************************************************
    // two-entry write buffer
    // ************************************************************
    host_port_pkg::addr_t buf_addr [2];
    host_port_pkg::word_t buf_data [2];
    logic [1:0] buf_cnt_reg;
    logic buf_wp_reg;
    logic buf_rp_reg;
    logic push;
    logic pop;
    logic buf_full;
    host_port_pkg::addr_t push_addr;
    assign buf_full = buf_cnt_reg == 2'h2;
    assign push_addr = muxed ? addr_reg : pins.host_addr_bus;
    assign push = data_access & ~pins.host_dir_select & ~buf_full; // R04
    assign pop = ram_wr_valid & ram_wr_ready;

    // buffer storage and pointers
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            buf_cnt_reg <= 2'h0;
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                buf_addr[buf_wp_reg] <= push_addr;
                buf_data[buf_wp_reg] <= pins.hd_to_dev;
                buf_wp_reg <= ~buf_wp_reg;
            end
            if (pop)
                buf_rp_reg <= ~buf_rp_reg;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // ram write port registered from buffer head
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            ram_wr_valid <= 1'b0;
            ram_wr_addr <= '0;
            ram_wr_data <= '0;
        end
        else
        begin
            ram_wr_valid <= (buf_cnt_reg - {1'b0, pop}) != 2'h0 | push;
            ram_wr_addr <= (buf_cnt_reg - {1'b0, pop}) != 2'h0 ? buf_addr[buf_rp_reg ^ pop] : push_addr;
            ram_wr_data <= (buf_cnt_reg - {1'b0, pop}) != 2'h0 ? buf_data[buf_rp_reg ^ pop] : pins.hd_to_dev;
        end
    end

    // ************************************************************
    // ready and read path
    // ************************************************************
    logic [3:0] busy_reg;
    logic rd_wait_reg;
    // busy countdown after each data transfer
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            busy_reg <= 4'h0;
            rd_wait_reg <= 1'b0;
            ram_rd_req <= 1'b0;
            ram_rd_addr <= '0;
        end
        else
        begin
            ram_rd_req <= data_access & pins.host_dir_select;
            ram_rd_addr <= push_addr;
            if (data_access & pins.host_dir_select)
                rd_wait_reg <= 1'b1;
            else if (ram_rd_valid)
                rd_wait_reg <= 1'b0;
            if (data_access)
                busy_reg <= BUSY_CYCLES;
            else if (busy_reg != 4'h0)
                busy_reg <= busy_reg - 4'h1;
        end
    end

    // ready output and its float enable
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            pins.host_ready_out <= 1'b0; // R18
            pins.host_ready_oe <= 1'b0;
        end
        else
        begin
            pins.host_ready_out <= busy_reg == 4'h0 & ~rd_wait_reg & ~buf_full & ~data_access; // R05
            pins.host_ready_oe <= pins.off_n & ~pins.iface_select_pin; // R06 R01
        end
    end

    // ************************************************************
    // control register, interrupts, data bus out
    // ************************************************************
    logic [1:0] irq_reg;
    logic ctrl_wr;
    assign ctrl_wr = strobe_fall & muxed & sel == `HP_SEL_CONTROL & ~pins.host_dir_select;

    // set wins over clear; nothing pends outside multiplexed mode
    always_ff @(posedge clk)
    begin
        if (port_rst | ~muxed)
            irq_reg <= 2'b00; // R09 R13
        else
        begin
            irq_reg[0] <= dsp_irq_set_a | (irq_reg[0] & ~(ctrl_wr & pins.hd_to_dev[`HP_CTRL_IRQ_A_BIT])); // R08
            irq_reg[1] <= dsp_irq_set_b | (irq_reg[1] & ~(ctrl_wr & pins.hd_to_dev[`HP_CTRL_IRQ_B_BIT])); // R08
        end
    end

    // interrupt pins, active low, floated by off
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            pins.host_irq_out_a_n <= 1'b1; // R18
            pins.host_irq_out_b_n <= 1'b1;
            pins.host_irq_oe <= 1'b0;
            subsys_reset <= 1'b1; // R10
        end
        else
        begin
            pins.host_irq_out_a_n <= ~irq_reg[0]; // R07
            pins.host_irq_out_b_n <= ~irq_reg[1]; // R07
            pins.host_irq_oe <= pins.off_n & ~pins.iface_select_pin; // R06
            subsys_reset <= 1'b0;
        end
    end

    // read data onto the data bus while a read strobe is low
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            pins.hd_from_dev <= '0;
            pins.hd_dev_oe <= 1'b0;
        end
        else
        begin
            if (ram_rd_valid)
                pins.hd_from_dev <= ram_rd_data;
            else if (strobe_fall & muxed & sel == `HP_SEL_CONTROL)
                pins.hd_from_dev <= {14'h0000, irq_reg};
            else if (strobe_fall & muxed & sel == `HP_SEL_ADDR)
                pins.hd_from_dev <= addr_reg[15:0];
            pins.hd_dev_oe <= active & ~strobe_n & pins.host_dir_select & pins.off_n;
        end
    end
endmodule : host_port_device

`default_nettype wire

// [host_port_host.sv]
// host_port_host.sv: host end driving the parallel host port pins
// assumes one request at a time on the command port
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module host_port_host (
    input wire logic clk,
    input wire logic rst,
    host_port_if.host pins,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire host_port_pkg::req_kind_t cmd_kind,
    input wire logic mode_nonmux,
    input wire logic [1:0] cmd_sel,
    input wire host_port_pkg::addr_t cmd_addr,
    input wire host_port_pkg::word_t cmd_wdata,
    output logic rsp_valid,
    output host_port_pkg::word_t rsp_data,
    output logic irq_a,
    output logic irq_b
);
    typedef enum logic [2:0] {IDLE, ASTRB, WAIT_RDY, STRB, FINISH} hstate_t;
    hstate_t state_reg;
    host_port_pkg::req_kind_t kind_reg;
    logic [2:0] hold_reg;

    // ************************************************************
    // transfer sequencer
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= IDLE;
            kind_reg <= host_port_pkg::REQ_READ;
            hold_reg <= 3'h0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            pins.host_chip_select_n <= 1'b1;
            pins.host_strobe_one_n <= 1'b1;
            pins.host_strobe_two_n <= 1'b1;
            pins.host_dir_select <= 1'b1;
            pins.host_addr_strobe_n <= 1'b1;
            pins.host_reg_select_0 <= 1'b0;
            pins.host_reg_select_1 <= 1'b0;
            pins.host_addr_bus <= '0;
            pins.hd_from_host <= '0;
            pins.hd_host_oe <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            case (state_reg)
                IDLE:
                begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid & cmd_ready)
                    begin
                        cmd_ready <= 1'b0;
                        kind_reg <= cmd_kind;
                        pins.host_chip_select_n <= 1'b0; // R14
                        pins.host_dir_select <= cmd_kind == host_port_pkg::REQ_READ; // R04
                        pins.host_reg_select_0 <= cmd_sel[0]; // R16
                        pins.host_reg_select_1 <= cmd_sel[1];
                        pins.host_addr_bus <= cmd_addr;
                        pins.hd_from_host <= cmd_kind == host_port_pkg::REQ_ADDR ? cmd_addr[15:0] : cmd_wdata;
                        pins.hd_host_oe <= cmd_kind != host_port_pkg::REQ_READ;
                        pins.host_addr_strobe_n <= ~(cmd_kind == host_port_pkg::REQ_ADDR & ~mode_nonmux); // R15
                        state_reg <= cmd_kind == host_port_pkg::REQ_ADDR ? ASTRB : WAIT_RDY;
                    end
                end
                ASTRB:
                begin
                    pins.host_addr_strobe_n <= 1'b1;
                    pins.hd_host_oe <= 1'b0;
                    state_reg <= FINISH;
                end
                WAIT_RDY:
                    if (pins.host_ready_out) // R05 R17
                    begin
                        pins.host_strobe_one_n <= 1'b0; // R03
                        hold_reg <= 3'h3;
                        state_reg <= STRB;
                    end
                STRB:
                    if (hold_reg != 3'h0)
                        hold_reg <= hold_reg - 3'h1;
                    else if (kind_reg != host_port_pkg::REQ_READ | pins.host_ready_out)
                    begin
                        pins.host_strobe_one_n <= 1'b1;
                        pins.hd_host_oe <= 1'b0;
                        rsp_data <= pins.hd_to_dev;
                        rsp_valid <= kind_reg == host_port_pkg::REQ_READ;
                        state_reg <= FINISH;
                    end
                FINISH:
                begin
                    pins.host_chip_select_n <= 1'b1;
                    state_reg <= IDLE;
                end
                default:
                    state_reg <= IDLE;
            endcase
        end
    end

    // straps and interrupt sampling
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pins.iface_select_pin <= 1'b1;
            pins.host_mode_pin <= 1'b0;
            pins.host_port_reset_pin_n <= 1'b0;
            irq_a <= 1'b0;
            irq_b <= 1'b0;
        end
        else
        begin
            pins.iface_select_pin <= 1'b0;
            pins.host_mode_pin <= mode_nonmux;
            pins.host_port_reset_pin_n <= 1'b1;
            irq_a <= ~pins.host_irq_out_a_n;
            irq_b <= ~pins.host_irq_out_b_n;
        end
    end
endmodule : host_port_host

`default_nettype wire

// [host_port_monitor.sv]
// host_port_monitor.sv: concurrent checks on the pins between host and device ends
// assumes one clock domain and plain copies of the interface signals as inputs
`timescale 1ns/1ps
`default_nettype none

module host_port_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic iface_select_pin,
    input wire logic host_mode_pin,
    input wire logic host_chip_select_n,
    input wire logic host_strobe_one_n,
    input wire logic host_dir_select,
    input wire logic host_reg_select_0,
    input wire logic host_reg_select_1,
    input wire logic [15:0] hd_to_dev,
    input wire logic hd_dev_oe,
    input wire logic hd_host_oe,
    input wire logic off_n,
    input wire logic host_ready_out,
    input wire logic host_ready_oe,
    input wire logic host_irq_out_a_n,
    input wire logic host_irq_out_b_n,
    input wire logic host_irq_oe
);
    // ****************************************
    // pin checks
    // ****************************************
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // strobe low with the port selected
    logic start;
    assign start = !host_strobe_one_n && !iface_select_pin && !host_chip_select_n;

    float_on_off_a : assert property (!off_n |=> !host_ready_oe && !host_irq_oe)
        else $error("ready or interrupt driven while off is low");
    select_release_a : assert property (iface_select_pin |=> !hd_dev_oe && !host_ready_oe)
        else $error("port pins driven while interface select is high");
    nonmux_irq_a : assert property (host_mode_pin |=> host_irq_out_a_n && host_irq_out_b_n)
        else $error("interrupt asserted in non-multiplexed mode");
    ready_drop_a : assert property ($fell(host_strobe_one_n) && start
        && (host_mode_pin || host_reg_select_0) |=> !host_ready_out)
        else $error("ready did not drop after strobe");
    write_busy_a : assert property ($fell(host_strobe_one_n) && start && !host_dir_select
        && (host_mode_pin || {host_reg_select_1, host_reg_select_0} == 2'h3)
        |=> !host_ready_out [*3] ##[1:40] host_ready_out)
        else $error("write busy period wrong");
    irq_clear_a : assert property ($fell(host_strobe_one_n) && start && !host_dir_select && !host_mode_pin
        && {host_reg_select_1, host_reg_select_0} == 2'h0 && hd_to_dev[0] |-> ##[1:8] host_irq_out_a_n)
        else $error("interrupt a not released by clear write");
    read_drive_a : assert property ($fell(host_strobe_one_n) && start && host_dir_select && off_n
        |-> ##[1:40] hd_dev_oe)
        else $error("read data never driven");
    strobe_wait_a : assert property ($fell(host_strobe_one_n) |-> $past(host_ready_out))
        else $error("strobe while port busy");
    cs_hold_a : assert property (!host_strobe_one_n |-> !host_chip_select_n)
        else $error("chip select released during strobe");
    no_contend_a : assert property (hd_dev_oe |-> !hd_host_oe)
        else $error("both ends drive the data bus");
endmodule : host_port_monitor

`default_nettype wire

// [tb.sv]
// tb.sv: self-checking bench joining host end and device end of the host port
// assumes both ends in host_port_if, a word RAM modelled here, 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk, rst;
    logic cmd_valid, cmd_ready, mode_nonmux, rsp_valid, irq_a, irq_b;
    host_port_pkg::req_kind_t cmd_kind;
    logic [1:0] cmd_sel;
    host_port_pkg::addr_t cmd_addr, ram_wr_addr, ram_rd_addr;
    host_port_pkg::word_t cmd_wdata, rsp_data, ram_wr_data, ram_rd_data, rd;
    logic ram_wr_valid, ram_wr_ready, ram_rd_req, ram_rd_valid;
    logic dsp_irq_set_a, dsp_irq_set_b, subsys_reset;
    logic [15:0] bus_keep;
    host_port_pkg::word_t mem [host_port_pkg::addr_t];
    host_port_pkg::addr_t wa_q[$];
    host_port_pkg::word_t wd_q[$];
    int errors = 0, checked = 0;

    host_port_if pif ();
    // data bus with bus holder
    assign pif.hd_to_dev = pif.hd_dev_oe ? pif.hd_from_dev : (pif.hd_host_oe ? pif.hd_from_host : bus_keep);
    always @(posedge clk) bus_keep <= pif.hd_to_dev;

    host_port_device host_port_device_i (.clk(clk), .rst(rst), .pins(pif), .ram_wr_valid(ram_wr_valid),
        .ram_wr_ready(ram_wr_ready), .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
        .ram_rd_req(ram_rd_req), .ram_rd_addr(ram_rd_addr), .ram_rd_valid(ram_rd_valid),
        .ram_rd_data(ram_rd_data), .dsp_irq_set_a(dsp_irq_set_a), .dsp_irq_set_b(dsp_irq_set_b),
        .subsys_reset(subsys_reset));
    host_port_host host_port_host_i (.clk(clk), .rst(rst), .pins(pif), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .mode_nonmux(mode_nonmux), .cmd_sel(cmd_sel),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .irq_a(irq_a), .irq_b(irq_b));
    host_port_monitor host_port_monitor_i (.clk(clk), .rst(rst), .iface_select_pin(pif.iface_select_pin),
        .host_mode_pin(pif.host_mode_pin), .host_chip_select_n(pif.host_chip_select_n),
        .host_strobe_one_n(pif.host_strobe_one_n), .host_dir_select(pif.host_dir_select),
        .host_reg_select_0(pif.host_reg_select_0), .host_reg_select_1(pif.host_reg_select_1),
        .hd_to_dev(pif.hd_to_dev), .hd_dev_oe(pif.hd_dev_oe), .hd_host_oe(pif.hd_host_oe),
        .off_n(pif.off_n), .host_ready_out(pif.host_ready_out), .host_ready_oe(pif.host_ready_oe),
        .host_irq_out_a_n(pif.host_irq_out_a_n), .host_irq_out_b_n(pif.host_irq_out_b_n),
        .host_irq_oe(pif.host_irq_oe));

    // ****************************************
    // clock and ram model
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // word ram: writes logged, reads answered one cycle after request
    always @(posedge clk)
    begin
        ram_rd_valid <= ram_rd_req;
        ram_rd_data <= mem.exists(ram_rd_addr) ? mem[ram_rd_addr] : 16'h0000;
        if (ram_wr_valid === 1'b1 && ram_wr_ready === 1'b1)
        begin
            mem[ram_wr_addr] = ram_wr_data;
            wa_q.push_back(ram_wr_addr);
            wd_q.push_back(ram_wr_data);
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // one host command, bounded waits
    task automatic xfer(input host_port_pkg::req_kind_t kind, input logic [1:0] sel,
                        input host_port_pkg::addr_t addr, input host_port_pkg::word_t wdata);
        int n;
        cmd_kind <= kind;
        cmd_sel <= sel;
        cmd_addr <= addr;
        cmd_wdata <= wdata;
        cmd_valid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 200);
        cmd_valid <= 1'b0;
        n = 0;
        rd = 16'hxxxx;
        do
        begin
            @(posedge clk);
            n++;
            if (rsp_valid === 1'b1)
                rd = rsp_data;
        end
        while (n < 200 && (kind == host_port_pkg::REQ_READ ? rsp_valid !== 1'b1 : cmd_ready !== 1'b1));
        if (n >= 200)
        begin
            errors++;
            summarize();
        end
    endtask : xfer

    task automatic expect_wr(input host_port_pkg::addr_t a, input host_port_pkg::word_t d);
        check(wa_q.size() > 0 ? wa_q.pop_front() : 18'h3_ffff, a);
        check(wd_q.size() > 0 ? wd_q.pop_front() : 16'hxxxx, d);
    endtask : expect_wr

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_nonmux;
        mode_nonmux <= 1'b1;
        xfer(host_port_pkg::REQ_WRITE, 2'h3, 18'h2_0005, 16'hA5C3);
        expect_wr(18'h2_0005, 16'hA5C3);
        xfer(host_port_pkg::REQ_READ, 2'h3, 18'h2_0005, 16'h0000);
        check(rd, 16'hA5C3);
        dsp_irq_set_a <= 1'b1;
        @(posedge clk);
        dsp_irq_set_a <= 1'b0;
        repeat (4) @(posedge clk);
        check(pif.host_irq_out_a_n, 1'b1);
    endtask : t_nonmux

    task automatic t_mux;
        mode_nonmux <= 1'b0;
        xfer(host_port_pkg::REQ_ADDR, 2'h2, 18'h0_1230, 16'h0000);
        xfer(host_port_pkg::REQ_WRITE, 2'h1, 18'h0_0000, 16'h1111);
        xfer(host_port_pkg::REQ_WRITE, 2'h1, 18'h0_0000, 16'h2222);
        expect_wr(18'h0_1230, 16'h1111);
        expect_wr(18'h0_1231, 16'h2222);
        xfer(host_port_pkg::REQ_ADDR, 2'h2, 18'h0_1231, 16'h0000);
        xfer(host_port_pkg::REQ_READ, 2'h3, 18'h0_0000, 16'h0000);
        check(rd, 16'h2222);
    endtask : t_mux

    task automatic t_irq;
        mode_nonmux <= 1'b0;
        dsp_irq_set_a <= 1'b1;
        dsp_irq_set_b <= 1'b1;
        @(posedge clk);
        dsp_irq_set_a <= 1'b0;
        dsp_irq_set_b <= 1'b0;
        repeat (4) @(posedge clk);
        check({pif.host_irq_out_b_n, pif.host_irq_out_a_n}, 2'h0);
        check({irq_b, irq_a}, 2'h3);
        xfer(host_port_pkg::REQ_READ, 2'h0, 18'h0_0000, 16'h0000);
        check(rd, 16'h0003);
        xfer(host_port_pkg::REQ_CTRL, 2'h0, 18'h0_0000, 16'h0001);
        repeat (4) @(posedge clk);
        check({pif.host_irq_out_b_n, pif.host_irq_out_a_n}, 2'h1);
        xfer(host_port_pkg::REQ_CTRL, 2'h0, 18'h0_0000, 16'h0002);
        repeat (4) @(posedge clk);
        check({pif.host_irq_out_b_n, pif.host_irq_out_a_n}, 2'h3);
    endtask : t_irq

    task automatic t_off;
        pif.off_n <= 1'b0;
        repeat (2) @(posedge clk);
        check({pif.host_ready_oe, pif.host_irq_oe}, 2'h0);
        pif.off_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(pif.host_ready_oe, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check({subsys_reset, pif.host_ready_out, pif.host_irq_out_a_n}, 3'h5);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : t_off

    task automatic t_stall;
        mode_nonmux <= 1'b1;
        ram_wr_ready <= 1'b0;
        fork
            begin
                xfer(host_port_pkg::REQ_WRITE, 2'h3, 18'h1_0000, 16'h0101);
                xfer(host_port_pkg::REQ_WRITE, 2'h3, 18'h1_0001, 16'h0202);
                xfer(host_port_pkg::REQ_WRITE, 2'h3, 18'h1_0002, 16'h0303);
            end
            begin
                repeat (25) @(posedge clk);
                ram_wr_ready <= 1'b1;
            end
        join
        repeat (10) @(posedge clk);
        expect_wr(18'h1_0000, 16'h0101);
        expect_wr(18'h1_0001, 16'h0202);
        expect_wr(18'h1_0002, 16'h0303);
    endtask : t_stall

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_kind = host_port_pkg::REQ_READ;
        cmd_sel = 2'h0;
        cmd_addr = 18'h0_0000;
        cmd_wdata = 16'h0000;
        mode_nonmux = 1'b0;
        ram_wr_ready = 1'b1;
        dsp_irq_set_a = 1'b0;
        dsp_irq_set_b = 1'b0;
        pif.off_n = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check(subsys_reset, 1'b0);
        t_nonmux();
        t_mux();
        t_irq();
        t_off();
        t_stall();
        summarize();
    end
endmodule : tb

`default_nettype wire
